/* File: core/llab_bridge.sv */
// receive fifo and the legacy link to stream bridge top
// assumes one clock pclk, apb master on the register side, stream peers outside
// Notes on behaviour
// - offered beat stays until ready accepts it
// - slave ready follows own capacity, not valid
// - transmit side is a stream master
// - receive side is a stream slave
// - stream master never samples ready before offering; legacy writer checks ready (not full) first
// - full and exists flags report link state
// - one 32-bit holding register per master
// - put loads holding register, sent at handshake
// - test reads holding valid, not stream lines
// - static parameter selects stream or legacy
// - blocking get waits, non-blocking never stalls
// - non-blocking latency fixed, blocking may vary
// - word order kept, no loss or duplication
`timescale 1ns/1ps

// ==========================================================
// receive fifo
// ==========================================================
module llab_fifo #(
    parameter int W = 33,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    // fill level
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PW = $clog2(DEPTH);

    // pointers wrap by themselves, hence power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [W-1:0] mem [DEPTH]; // storage
    logic [PW-1:0] wr_ptr_r; // next slot to fill
    logic [PW-1:0] rd_ptr_r; // oldest word
    logic [$clog2(DEPTH+1)-1:0] cnt_r; // words held
    logic [$clog2(DEPTH+1)-1:0] cnt_nxt;
    logic in_ready_r; // registered so the port comes from a flop
    logic push;
    logic pop;

    assign push = in_valid & in_ready_r;
    assign pop = out_valid & out_ready;
    assign in_ready = in_ready_r;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign count = cnt_r;

    // level after this edge
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers, level and ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            in_ready_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            // capacity only, never a function of in_valid
            in_ready_r <= (cnt_nxt != DEPTH[$clog2(DEPTH+1)-1:0]);
        end
    end

    default clocking cb_f @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fifo_count: assert property (
        push && !pop |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("fifo level did not grow on push");

    a_fifo_ready: assert property (
        in_ready_r |-> cnt_r != DEPTH[$clog2(DEPTH+1)-1:0])
        else $error("fifo ready while full");

endmodule : llab_fifo

// ==========================================================
// bridge top
// ==========================================================
module llab_bridge
    import llab_pkg::*;
#(
    parameter int DATA_W = 32, // stream word width
    parameter bit STREAM_AXIS = 1'b1 // 1 = stream handshake, 0 = legacy link
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [llab_pkg::ADDR_W-1:0] paddr,
    input wire logic [llab_pkg::BUS_W-1:0] pwdata,
    output logic [llab_pkg::BUS_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // outgoing stream (master)
    output logic m_tvalid,
    input wire logic m_tready,
    output logic [DATA_W-1:0] m_tdata,
    output logic m_tlast,
    // incoming stream (slave)
    input wire logic s_tvalid,
    output logic s_tready,
    input wire logic [DATA_W-1:0] s_tdata,
    input wire logic s_tlast
);
    import llab_pkg::*;

    // words are carried in one apb data word
    if (DATA_W < 1 || DATA_W > BUS_W) begin : g_bad_width
        $error("stream width must be 1 to 32 bits");
    end

    // ==========================================================
    // state
    // ==========================================================
    llab_apb_st_t st_r; // bus response state
    logic ctrl_last_r; // control bit for next put
    logic ctrl_block_r; // get waits for data
    logic hold_valid_r; // holding register owns an unsent word
    logic [DATA_W-1:0] hold_data_r; // output holding register
    logic hold_last_r; // its control bit
    logic m_tvalid_r; // offered beat or legacy write pulse
    logic [BUS_W-1:0] prdata_r; // read answer
    logic pready_r; // one-cycle answer
    logic pslverr_r; // unmapped address
    logic pop_due_r; // decided get carried a word, pop it at the answer edge

    // receive fifo wires
    logic rx_valid; // word waiting
    logic rx_pop; // get consumes head
    logic [DATA_W:0] rx_word; // {last, data}
    logic rx_ready; // registered space flag
    logic [$clog2(FIFO_DEPTH+1)-1:0] rx_count;

    // ==========================================================
    // decode
    // ==========================================================
    logic acc; // access phase not yet answered
    logic hit_ctrl;
    logic hit_put;
    logic hit_stat;
    logic hit_get;
    logic tx_accept; // word leaves the holding register
    logic put_ok; // holding register can take a word
    logic get_ok; // get may finish now
    logic go; // answer at next edge
    logic put_fire;
    logic get_fire;
    logic resp; // answer edge, request still held by the master
    logic [BUS_W-1:0] stat_word;

    assign acc = psel & penable & (st_r == ST_IDLE);
    assign hit_ctrl = (paddr == REG_CTRL);
    assign hit_put = (paddr == REG_PUT);
    assign hit_stat = (paddr == REG_STAT);
    assign hit_get = (paddr == REG_GET);

    // stream mode leaves at handshake, legacy at the write pulse
    assign tx_accept = STREAM_AXIS ? (m_tvalid_r & m_tready) : m_tvalid_r;

    // reload allowed in the cycle the old word leaves
    assign put_ok = !hold_valid_r || tx_accept;
    // non-blocking get never stalls the bus
    assign get_ok = rx_valid || !ctrl_block_r;

    assign go = acc && !(pwrite && hit_put && !put_ok) && !(!pwrite && hit_get && !get_ok);
    // side effects wait for the edge at which the master sees pready
    assign resp = psel & penable & (st_r == ST_RESP);
    assign put_fire = resp && pwrite && hit_put;
    assign get_fire = resp && !pwrite && hit_get;
    // a word arriving after an empty get is kept, not lost
    assign rx_pop = get_fire && pop_due_r;

    // status: flags come from internal state, not the stream lines
    always_comb begin
        stat_word = '0;
        stat_word[STAT_HOLD_BIT] = hold_valid_r;
        stat_word[STAT_TXFULL_BIT] = hold_valid_r;
        stat_word[STAT_EXISTS_BIT] = rx_valid;
        stat_word[STAT_RXFULL_BIT] = !rx_ready;
        stat_word[STAT_LAST_BIT] = rx_valid & rx_word[DATA_W];
        stat_word[STAT_MODE_BIT] = STREAM_AXIS;
    end

    // ==========================================================
    // apb response
    // ==========================================================
    // pready rises one edge after the decision; side effects land at the next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
            pop_due_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (go) begin
                        st_r <= ST_RESP;
                        pready_r <= 1'b1;
                        pslverr_r <= !(hit_ctrl || hit_put || hit_stat || hit_get);
                        prdata_r <= '0;
                        pop_due_r <= !pwrite && hit_get && rx_valid;
                        if (!pwrite && hit_ctrl) begin
                            prdata_r[CTRL_LAST_BIT] <= ctrl_last_r;
                            prdata_r[CTRL_BLOCK_BIT] <= ctrl_block_r;
                        end else if (!pwrite && hit_stat) begin
                            prdata_r <= stat_word;
                        end else if (!pwrite && hit_get && rx_valid) begin
                            // empty non-blocking get answers zero
                            prdata_r <= BUS_W'(rx_word[DATA_W-1:0]);
                        end
                    end
                end
                ST_RESP: begin
                    // side effects land at this edge, then the master lets go
                    st_r <= ST_IDLE;
                    pop_due_r <= 1'b0;
                    pready_r <= 1'b0;
                    pslverr_r <= 1'b0;
                end
                default: begin
                    st_r <= ST_IDLE;
                    pready_r <= 1'b0;
                    pslverr_r <= 1'b0;
                end
            endcase
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_last_r <= CTRL_RST[CTRL_LAST_BIT];
            ctrl_block_r <= CTRL_RST[CTRL_BLOCK_BIT];
        end else if (resp && pwrite && hit_ctrl) begin
            ctrl_last_r <= pwdata[CTRL_LAST_BIT];
            ctrl_block_r <= pwdata[CTRL_BLOCK_BIT];
        end
    end

    // ==========================================================
    // transmit holding register
    // ==========================================================
    // a put in the leaving cycle keeps valid set: load wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_valid_r <= 1'b0;
            hold_data_r <= '0;
            hold_last_r <= 1'b0;
        end else begin
            if (put_fire) begin
                hold_valid_r <= 1'b1;
                hold_data_r <= pwdata[DATA_W-1:0];
                hold_last_r <= ctrl_last_r;
            end else if (tx_accept) begin
                hold_valid_r <= 1'b0;
            end
        end
    end

    // valid: held beat in stream mode, single write pulse in legacy mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_tvalid_r <= 1'b0;
        end else if (STREAM_AXIS) begin
            // offered whenever a word is held; ready is not looked at first
            m_tvalid_r <= put_fire || (hold_valid_r && !tx_accept);
        end else begin
            // legacy writer consults full (= not ready) before writing
            m_tvalid_r <= hold_valid_r && !m_tvalid_r && m_tready;
        end
    end

    assign m_tvalid = m_tvalid_r;
    assign m_tdata = hold_data_r;
    assign m_tlast = hold_last_r;

    // ==========================================================
    // receive path
    // ==========================================================
    // legacy writers honour full, so push is valid and ready in both modes
    llab_fifo #(
        .W(DATA_W + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(s_tvalid),
        .in_data({s_tlast, s_tdata}),
        .in_ready(rx_ready),
        .out_valid(rx_valid),
        .out_data(rx_word),
        .out_ready(rx_pop),
        .count(rx_count)
    );

    assign s_tready = rx_ready;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_valid_held: assert property (
        STREAM_AXIS && m_tvalid && !m_tready |=>
            m_tvalid && $stable(m_tdata) && $stable(m_tlast))
        else $error("offered beat withdrawn or changed");

    a_offer_now: assert property (
        STREAM_AXIS && hold_valid_r |-> m_tvalid)
        else $error("held word not offered");

    a_put_loads: assert property (
        put_fire |=> hold_valid_r && m_tdata == $past(pwdata[DATA_W-1:0]))
        else $error("put did not load holding register");

    a_hold_clear: assert property (
        tx_accept && !put_fire |=> !hold_valid_r)
        else $error("holding valid kept after acceptance");

    a_test_bit: assert property (
        acc && go && !pwrite && hit_stat |=>
            pready && prdata[STAT_HOLD_BIT] == $past(hold_valid_r))
        else $error("test bit does not show holding state");

    a_legacy_pulse: assert property (
        !STREAM_AXIS && m_tvalid |=> !m_tvalid)
        else $error("legacy write strobe longer than one cycle");

    a_rx_ready: assert property (
        s_tready |-> rx_count != FIFO_DEPTH[$clog2(FIFO_DEPTH+1)-1:0])
        else $error("receive ready while buffer full");

    a_block_wait: assert property (
        acc && !pwrite && hit_get && ctrl_block_r && !rx_valid |=> !pready)
        else $error("blocking get finished without data");

    a_fixed_lat: assert property (
        acc && !pwrite && hit_get && !ctrl_block_r |=> pready ##1 !pready)
        else $error("non-blocking get latency not fixed");

    a_rx_order: assert property (
        rx_pop && !(s_tvalid && s_tready) |=> rx_count == $past(rx_count) - 1'b1)
        else $error("get did not consume exactly one word");

endmodule : llab_bridge

/* File: core/llab_pkg.sv */
// shared constants for the legacy link to stream bridge
// assumes an apb master with 32-bit data and byte addresses
package llab_pkg;

    // ==========================================================
    // bus geometry
    // ==========================================================
    localparam int ADDR_W = 12; // apb address width
    localparam int BUS_W = 32; // apb data width

    // ==========================================================
    // register byte offsets
    // ==========================================================
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000; // control
    localparam logic [ADDR_W-1:0] REG_PUT = 12'h004; // put into holding register
    localparam logic [ADDR_W-1:0] REG_STAT = 12'h008; // status (test)
    localparam logic [ADDR_W-1:0] REG_GET = 12'h00C; // get from receive fifo

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int CTRL_LAST_BIT = 0; // control bit sent with next put
    localparam int CTRL_BLOCK_BIT = 1; // get waits for data when set
    localparam int STAT_HOLD_BIT = 0; // holding register owns unsent word
    localparam int STAT_TXFULL_BIT = 1; // legacy full on transmit side
    localparam int STAT_EXISTS_BIT = 2; // receive data waiting
    localparam int STAT_RXFULL_BIT = 3; // receive fifo full
    localparam int STAT_LAST_BIT = 4; // control bit of waiting word
    localparam int STAT_MODE_BIT = 5; // 1 = stream signalling

    // ==========================================================
    // reset values and sizes
    // ==========================================================
    localparam logic [BUS_W-1:0] CTRL_RST = 32'h0000_0002; // blocking get
    localparam int FIFO_DEPTH = 16; // receive buffer words

    // bus response state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } llab_apb_st_t;

endpackage : llab_pkg

/* File: tb/llab_peer.sv */
// far-side stream peer: a slave that takes outgoing words, a master that feeds incoming ones
// assumes one clock shared with the bridge and an active low asynchronous reset
`timescale 1ns/1ps

// ==========================================================
// stream peer model
// ==========================================================
module llab_peer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // outgoing stream, peer is the slave
    input wire logic m_tvalid,
    output logic m_tready,
    input wire logic [31:0] m_tdata,
    input wire logic m_tlast,
    // incoming stream, peer is the master
    output logic s_tvalid,
    input wire logic s_tready,
    output logic [31:0] s_tdata,
    output logic s_tlast,
    // bench control
    input wire logic hold_off,
    input wire logic src_go,
    input wire logic [7:0] src_n
);
    logic [31:0] rnd_r; // own random source for ready
    logic [7:0] left_r; // words still to offer
    logic [15:0] idx_r; // index of the offered word

    // ready follows own whim and hold_off only, never valid, so stalls land anywhere
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rnd_r <= 32'h0000_5a3c;
        end else begin
            rnd_r <= rnd_r[0] ? ((rnd_r >> 1) ^ 32'h8020_0003) : (rnd_r >> 1);
        end
    end
    assign m_tready = ~hold_off & (rnd_r[0] | rnd_r[3]);

    // source counter: a beat leaves only at a handshake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_r <= 8'h00;
            idx_r <= 16'h0000;
        end else if (src_go) begin
            left_r <= src_n;
            idx_r <= 16'h0000;
        end else if (s_tvalid && s_tready) begin
            left_r <= left_r - 8'h01;
            idx_r <= idx_r + 16'h0001;
        end
    end
    // idle lines show the inverse of the last beat, not a stale copy
    assign s_tvalid = (left_r != 8'h00);
    assign s_tdata = s_tvalid ? {16'hc0de, idx_r} : ~{16'hc0de, idx_r - 16'h0001};
    assign s_tlast = s_tvalid ? (idx_r[1:0] == 2'd3) : (idx_r[1:0] != 2'd0);
endmodule : llab_peer

/* File: tb/legacy_link_to_axis_bridge_test.sv */
// self-checking bench for the bridge: apb master tasks, stream peer, scoreboards
// assumes the bridge in stream mode with its 16-word receive fifo
`timescale 1ns/1ps

// ==========================================================
// bench top
// ==========================================================
module legacy_link_to_axis_bridge_test;
    import llab_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [BUS_W-1:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, m_tvalid, m_tready, m_tlast, s_tvalid, s_tready, s_tlast;
    logic [31:0] m_tdata, s_tdata, seed = 32'h0000_63cd;
    logic hold_off = 1'b1, src_go = 1'b0;
    logic [7:0] src_n = 8'h00;
    logic [32:0] exp_q[$], got_q[$], ew; // {last, data}
    int n_mismatch = 0, n_checks = 0, cyc = 0, t0, i;

    llab_bridge llab_bridge_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .m_tvalid(m_tvalid),
        .m_tready(m_tready), .m_tdata(m_tdata), .m_tlast(m_tlast), .s_tvalid(s_tvalid),
        .s_tready(s_tready), .s_tdata(s_tdata), .s_tlast(s_tlast));
    llab_peer llab_peer_inst (.clk(pclk), .rst_n(presetn), .m_tvalid(m_tvalid),
        .m_tready(m_tready), .m_tdata(m_tdata), .m_tlast(m_tlast), .s_tvalid(s_tvalid),
        .s_tready(s_tready), .s_tdata(s_tdata), .s_tlast(s_tlast), .hold_off(hold_off),
        .src_go(src_go), .src_n(src_n));

    // clock and a cycle counter for latency checks
    initial begin
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (m_tvalid === 1'b1 && m_tready === 1'b1) got_q.push_back({m_tlast, m_tdata});
    end

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction : lfsr
    // word the peer offers at a given index, tlast on every fourth
    function automatic logic [32:0] src_exp(input int k);
        return {(k % 4) == 3, 16'hc0de, k[15:0]};
    endfunction : src_exp
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk
    // one apb transfer; a stall past the bound ends the run
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 500; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 500) begin
            n_mismatch++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_until_drained(input int n);
        int k;
        for (k = 0; k < 2000 && !(got_q.size() == n && m_tvalid === 1'b0); k++) @(posedge pclk);
        if (k == 2000) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : wait_until_drained

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, stream mode reported
        apb(0, REG_STAT, 0);
        chk("stat after reset", 33'h0_0000_0020, {er, rd});
        apb(0, REG_CTRL, 0);
        chk("ctrl after reset", {1'b0, CTRL_RST}, {er, rd});
        // test reports the held word while the far side stalls
        apb(1, REG_PUT, 32'h1234_abcd);
        exp_q.push_back({1'b0, 32'h1234_abcd});
        apb(0, REG_STAT, 0);
        chk("stat holding", 33'h0_0000_0023, {er, rd});
        repeat (5) @(posedge pclk);
        chk("valid held", 33'h1, {32'h0, m_tvalid});
        hold_off <= 1'b0;
        // random puts with random last bits against random ready
        for (i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            apb(1, REG_CTRL, 32'h0000_0002 | seed[4]);
            apb(1, REG_PUT, seed);
            exp_q.push_back({seed[4], seed});
        end
        wait_until_drained(exp_q.size());
        chk("words sent", exp_q.size(), got_q.size());
        foreach (exp_q[j]) chk("sent word", exp_q[j], got_q[j]);
        apb(0, REG_STAT, 0);
        chk("stat drained", 33'h0_0000_0020, {er, rd});
        $display("test transmit done");
        // fill the receive fifo past its depth, then drain in order
        src_n <= 8'd18;
        src_go <= 1'b1;
        @(posedge pclk);
        src_go <= 1'b0;
        for (i = 0; i < 200 && s_tready !== 1'b0; i++) @(posedge pclk);
        if (i == 200) begin
            n_mismatch++;
            wrap_up();
        end
        apb(0, REG_STAT, 0);
        chk("stat rx full", 33'h0_0000_002c, {er, rd});
        for (i = 0; i < 18; i++) begin
            ew = src_exp(i);
            apb(0, REG_STAT, 0);
            chk("head last bit", {32'h0, ew[32]}, {32'h0, rd[STAT_LAST_BIT]});
            apb(0, REG_GET, 0);
            chk("received word", {1'b0, ew[31:0]}, {er, rd});
        end
        $display("test receive done");
        // non-blocking get on an empty fifo answers at once
        apb(1, REG_CTRL, 32'h0000_0000);
        t0 = cyc;
        apb(0, REG_GET, 0);
        chk("empty get", 33'h0, {er, rd});
        chk("fixed latency", 1, (cyc - t0) <= 4);
        // blocking get waits for the word to arrive
        apb(1, REG_CTRL, 32'h0000_0002);
        t0 = cyc;
        fork
            apb(0, REG_GET, 0);
            begin
                repeat (20) @(posedge pclk);
                src_n <= 8'd1;
                src_go <= 1'b1;
                @(posedge pclk);
                src_go <= 1'b0;
            end
        join
        ew = src_exp(0);
        chk("blocking get", {1'b0, ew[31:0]}, {er, rd});
        chk("blocking waited", 1, (cyc - t0) >= 20);
        $display("test blocking done");
        // unmapped, misaligned and write-only places
        apb(0, 12'h010, 0);
        chk("unmapped read err", 1, er);
        apb(1, 12'h002, 32'h0000_0001);
        chk("misaligned write err", 1, er);
        apb(0, REG_PUT, 0);
        chk("put reads zero", 33'h0, {er, rd});
        $display("test decode done");
        wrap_up();
    end
endmodule : legacy_link_to_axis_bridge_test
